// [rtl/seq_pkg.sv]
// Constants, field layouts and state types of the reader command sequencer.
package seq_pkg;

	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] CMD_IDLE     = 8'h00;
	localparam logic [7:0] CMD_EE_FETCH = 8'h03;
	localparam logic [7:0] CMD_CFG_LOAD = 8'h07;
	localparam logic [7:0] CMD_CHKSUM   = 8'h12;
	localparam logic [7:0] CMD_TRANSMIT = 8'h1A;
	localparam logic [7:0] CMD_BOOT     = 8'h3F;

	// ****************************************
	// Register offsets; the page is address bits 5..3
	// ****************************************
	localparam logic [5:0] ADDR_STATUS     = 6'h00;
	localparam logic [5:0] ADDR_COMMAND    = 6'h01;
	localparam logic [5:0] ADDR_FIFO_DATA  = 6'h02;
	localparam logic [5:0] ADDR_FIFO_LEVEL = 6'h03;
	localparam logic [5:0] ADDR_FLAGS      = 6'h04;
	localparam logic [5:0] ADDR_CHK_LOW    = 6'h05;
	localparam logic [5:0] ADDR_CHK_HIGH   = 6'h06;
	localparam logic [5:0] ADDR_REDUND     = 6'h08;
	localparam logic [5:0] ADDR_BIT_PERIOD = 6'h09;
	localparam logic [2:0] PAGE_ZERO       = 3'h0;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int         RED_TX_CHK_BIT  = 0;
	localparam int         RED_CRC8_BIT    = 1;
	localparam int         RED_LEGACY_BIT  = 2;
	localparam int         FLAG_CMD_DONE   = 0;
	localparam int         FLAG_TX_DONE    = 1;
	localparam logic [7:0] REDUND_RST      = 8'h00;
	localparam logic [7:0] BIT_PERIOD_RST  = 8'h07;

	// ****************************************
	// FIFO, EEPROM and framing
	// ****************************************
	localparam int         FIFO_AW       = 6;
	localparam int         FIFO_DEPTH    = 64;
	localparam logic [6:0] FIFO_FULL_LVL = 7'h40;
	localparam int         EE_AW         = 9;
	localparam logic [8:0] KEY_START     = 9'h080;
	localparam logic [8:0] BOOT_EE_ADDR  = 9'h010;
	localparam logic [7:0] CFG_LEN       = 8'h02;
	localparam logic [7:0] SOF_PATTERN   = 8'h1E;
	localparam logic [3:0] SOF_LEN       = 4'h8;
	localparam logic [7:0] EOF_PATTERN   = 8'h3C;
	localparam logic [3:0] EOF_LEN       = 4'h8;
	localparam logic [7:0] START_PATTERN = 8'h01;
	localparam logic [3:0] START_LEN     = 4'h1;
	localparam logic [3:0] BYTE_LEN      = 4'h8;

	// ****************************************
	// Check-sum coprocessor
	// ****************************************
	localparam logic [15:0] CRC16_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC16_POLY   = 16'h8408;
	localparam logic [15:0] CRC8_PRESET  = 16'h00FF;
	localparam logic [15:0] CRC8_POLY    = 16'h00B8;

	// ****************************************
	// Modem phase codes and command states
	// ****************************************
	localparam logic [2:0] MODEM_IDLE  = 3'h0;
	localparam logic [2:0] MODEM_ARMED = 3'h1;
	localparam logic [2:0] MODEM_SOF   = 3'h2;
	localparam logic [2:0] MODEM_DATA  = 3'h3;
	localparam logic [2:0] MODEM_CHK   = 3'h4;
	localparam logic [2:0] MODEM_EOF   = 3'h5;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_BOOT  = 6'h02,
		ST_FETCH = 6'h04,
		ST_CFG   = 6'h08,
		ST_CALC  = 6'h10,
		ST_TX    = 6'h20
	} seq_state_t;

endpackage

// [rtl/chk_if.sv]
// Carrier between the command sequencer and its check-sum coprocessor.
`timescale 1ns/10ps
interface chk_if;
	logic        clear;
	logic        valid;
	logic        crc8;
	logic [7:0]  data;
	logic [15:0] result;

	modport seq  (output clear, output valid, output crc8, output data, input result);
	modport unit (input clear, input valid, input crc8, input data, output result);
endinterface

// [rtl/checksum_unit.sv]
// Byte-wide check-sum coprocessor, eight or sixteen bit, one byte per clock.
`timescale 1ns/10ps
module checksum_unit
	import seq_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Sequencer side
	chk_if.unit      chk
);

	logic [15:0] crc_ff;
	logic [15:0] nxt_crc;

	// Folds the byte in, least significant bit first.
	always_comb begin
		logic fb;
		fb = 1'b0;
		nxt_crc = crc_ff;
		for (int i = 0; i < 8; i++) begin
			fb = nxt_crc[0] ^ chk.data[i];
			nxt_crc = nxt_crc >> 1;
			if (fb) begin
				nxt_crc = nxt_crc ^ (chk.crc8 ? CRC8_POLY : CRC16_POLY);
			end
		end
	end

	// Holds the running value; clear presets it for the chosen width.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			crc_ff <= CRC16_PRESET;
		end else if (chk.clear) begin
			crc_ff <= chk.crc8 ? CRC8_PRESET : CRC16_PRESET;
		end else if (chk.valid) begin
			crc_ff <= nxt_crc;
		end
	end

	assign chk.result = crc_ff;

endmodule // checksum_unit

// [rtl/reader_command_sequencer_tx.sv]
// Command sequencer with FIFO, EEPROM commands, boot, idle and RF transmit.
// Operation
// - A command starts on a command write; the FIFO is never cleared then.
// - Fetch 03h takes address low, high, count; returns bytes, never key storage.
// - Config load 07h takes address low, high; loads registers from EEPROM.
// - Check-sum 12h folds FIFO bytes; result sits in low and high registers.
// - Boot 3Fh starts on supply power-up or reset pin fall, never by write.
// - Boot resets configuration bits, then loads registers from EEPROM.
// - Boot completion enters idle automatically.
// - During boot only page 0 reads are served.
// - A command write during boot neither stops nor replaces boot.
// - Idle 00h waits; a command ending by itself sets the done flag.
// - Writing idle stops any command but boot, without the done flag.
// - Cancelling by idle leaves FIFO contents untouched.
// - Transmit 1Ah moves FIFO bytes to the transmitter; host write starts it.
// - A frame preloaded in the FIFO goes out without further host help.
// - Transmit on empty FIFO arms and starts with the first byte.
// - Bytes written during transmit are appended; host keeps the stream fed.
// - Transmitter needing a byte with empty FIFO ends transmit, back to idle.
// - Transmission complete sets the transmit-done flag.
// - Another command written during transmit halts output next clock.
// - Standard frame: SOF, data, EOF; legacy: start pulse, data, no EOF.
// - With check-sum enable set, the check-sum is appended to the stream.
// - Last data bit start samples FIFO into accept-more; low ends the frame.
`timescale 1ns/10ps
module reader_command_sequencer_tx
	import seq_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Register port
	input  wire logic [5:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	// Power-up and reset events
	input  wire logic             digital_supply_pin,
	input  wire logic             analog_supply_pin,
	input  wire logic             reset_powerdown_pin,
	// EEPROM read port
	output logic      [EE_AW-1:0] ee_addr,
	output logic                  ee_rd,
	input  wire logic [7:0]       ee_rdata,
	// RF transmitter
	output logic                  tx_out,
	output logic                  tx_en
);

	// ****************************************
	// Declarations
	// ****************************************
	seq_state_t       state_ff;
	logic             dsup_prev_ff, asup_prev_ff, rpd_prev_ff;
	logic             boot_trig, boot_on, page0, bus_wr, host_cmd_wr, tx_start, cmd_known;
	logic [7:0]       fifo_mem [FIFO_DEPTH];
	logic [FIFO_AW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [6:0]       level_ff;
	logic             empty, full, fifo_avail, push, pop, host_push, host_pop, int_pop;
	logic [7:0]       fifo_head, push_data;
	logic [1:0]       arg_cnt_ff, args_need;
	logic             running, arg_pop, calc_pop, cmd_finish;
	logic [EE_AW-1:0] ee_addr_ff;
	logic [7:0]       ee_cnt_ff;
	logic             ee_rd_ff, ee_pend_ff, ee_issue, ee_push, cfg_fill;
	logic [7:0]       redund_ff, bit_period_ff;
	logic [1:0]       flags_ff;
	logic [7:0]       rdata_ff;
	logic [2:0]       phase_ff, nxt_phase;
	logic [7:0]       shift_ff, nxt_word;
	logic [3:0]       bits_ff, nxt_len;
	logic [7:0]       tick_ff;
	logic             accept_ff, chk_hi_ff, tx_out_ff, tx_en_ff;
	logic             tx_abort, tick_evt, tx_pop, tx_finish;

	chk_if chk_bus ();

	checksum_unit u_chk (
		.core_clk (core_clk),
		.rst      (rst),
		.chk      (chk_bus)
	);

	// ****************************************
	// Boot triggers and bus decode
	// ****************************************

	// Remembers the previous pin levels for edge detection.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dsup_prev_ff <= 1'b1;
			asup_prev_ff <= 1'b1;
			rpd_prev_ff  <= 1'b0;
		end else begin
			dsup_prev_ff <= digital_supply_pin;
			asup_prev_ff <= analog_supply_pin;
			rpd_prev_ff  <= reset_powerdown_pin;
		end
	end

	// Supply power-up or a falling reset pin restarts boot.
	assign boot_trig = (digital_supply_pin & ~dsup_prev_ff) | (analog_supply_pin & ~asup_prev_ff)
	                 | (~reset_powerdown_pin & rpd_prev_ff);
	assign boot_on     = (state_ff == ST_BOOT);
	assign page0       = (reg_addr[5:3] == PAGE_ZERO);
	assign bus_wr      = reg_wr & ~boot_on;
	assign host_cmd_wr = bus_wr & (reg_addr == ADDR_COMMAND);
	assign tx_start    = host_cmd_wr & (reg_wdata == CMD_TRANSMIT);
	assign cmd_known   = host_cmd_wr & (reg_wdata inside {CMD_IDLE, CMD_EE_FETCH, CMD_CFG_LOAD,
	                                                      CMD_CHKSUM, CMD_TRANSMIT});

	// ****************************************
	// FIFO, 64 bytes
	// ****************************************
	assign empty      = (level_ff == 7'h00);
	assign full       = (level_ff == FIFO_FULL_LVL);
	assign fifo_head  = fifo_mem[rd_ptr_ff];
	assign host_pop   = reg_rd & (reg_addr == ADDR_FIFO_DATA) & ~empty & (page0 | ~boot_on);
	assign fifo_avail = ~empty & ~host_pop;
	assign int_pop    = arg_pop | calc_pop | tx_pop;
	assign host_push  = bus_wr & (reg_addr == ADDR_FIFO_DATA) & ~full & ~ee_push;
	assign push       = host_push | ee_push;
	assign pop        = host_pop | int_pop;
	assign push_data  = ee_push ? ee_rdata : reg_wdata;

	// Stores pushed bytes.
	always_ff @(posedge core_clk) begin
		if (push) begin
			fifo_mem[wr_ptr_ff] <= push_data;
		end
	end

	// Pointers and level; no command start or cancel touches them.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			level_ff  <= 7'h00;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			level_ff <= level_ff + {6'h00, push} - {6'h00, pop};
		end
	end

	// ****************************************
	// Command state machine
	// ****************************************
	assign args_need  = (state_ff == ST_FETCH) ? 2'h3 : 2'h2;
	assign running    = boot_on | (((state_ff == ST_FETCH) | (state_ff == ST_CFG)) & (arg_cnt_ff == args_need));
	assign arg_pop    = ((state_ff == ST_FETCH) | (state_ff == ST_CFG)) & ~running & fifo_avail;
	assign calc_pop   = (state_ff == ST_CALC) & fifo_avail;
	assign ee_issue   = running & (ee_cnt_ff != 8'h00) & ~ee_rd_ff & ~ee_pend_ff & ~((state_ff == ST_FETCH) & full);
	assign ee_push    = ee_pend_ff & (state_ff == ST_FETCH) & (ee_addr_ff < KEY_START) & ~full;
	assign cfg_fill   = ee_pend_ff & ((state_ff == ST_CFG) | boot_on);
	assign cmd_finish = (running & (ee_cnt_ff == 8'h00) & ~ee_rd_ff & ~ee_pend_ff)
	                  | ((state_ff == ST_CALC) & empty) | tx_finish;

	// Steps commands; host writes decode, self-ending commands drop to idle.
	always_ff @(posedge core_clk) begin
		if (rst || boot_trig) begin
			state_ff   <= ST_BOOT;
			arg_cnt_ff <= 2'h0;
			ee_addr_ff <= BOOT_EE_ADDR;
			ee_cnt_ff  <= CFG_LEN;
			ee_rd_ff   <= 1'b0;
			ee_pend_ff <= 1'b0;
		end else if (cmd_known) begin
			arg_cnt_ff <= 2'h0;
			ee_cnt_ff  <= 8'h00;
			ee_rd_ff   <= 1'b0;
			ee_pend_ff <= 1'b0;
			case (reg_wdata)
				CMD_EE_FETCH: state_ff <= ST_FETCH;
				CMD_CFG_LOAD: state_ff <= ST_CFG;
				CMD_CHKSUM:   state_ff <= ST_CALC;
				CMD_TRANSMIT: state_ff <= ST_TX;
				default:      state_ff <= ST_IDLE;
			endcase
		end else if (cmd_finish) begin
			state_ff <= ST_IDLE;
		end else begin
			ee_rd_ff   <= ee_issue;
			ee_pend_ff <= ee_rd_ff;
			if (arg_pop) begin
				arg_cnt_ff <= arg_cnt_ff + 2'h1;
				case (arg_cnt_ff)
					2'h0: ee_addr_ff[7:0] <= fifo_head;
					2'h1: begin
						ee_addr_ff[8] <= fifo_head[0];
						ee_cnt_ff     <= CFG_LEN;
					end
					default: ee_cnt_ff <= fifo_head;
				endcase
			end
			if (ee_pend_ff) begin
				ee_addr_ff <= ee_addr_ff + 1'b1;
				ee_cnt_ff  <= ee_cnt_ff - 8'h01;
			end
		end
	end

	assign ee_addr = ee_addr_ff;
	assign ee_rd   = ee_rd_ff;

	// ****************************************
	// Configuration registers and flags
	// ****************************************

	// Boot entry resets configuration; EEPROM loads and host writes follow.
	always_ff @(posedge core_clk) begin
		if (rst || boot_trig) begin
			redund_ff     <= REDUND_RST;
			bit_period_ff <= BIT_PERIOD_RST;
		end else if (cfg_fill) begin
			if (ee_cnt_ff == CFG_LEN) begin
				redund_ff <= ee_rdata;
			end else begin
				bit_period_ff <= ee_rdata;
			end
		end else if (bus_wr && reg_addr == ADDR_REDUND) begin
			redund_ff <= reg_wdata;
		end else if (bus_wr && reg_addr == ADDR_BIT_PERIOD) begin
			bit_period_ff <= reg_wdata;
		end
	end

	// Sticky flags, write one to clear; a new event wins over the clear.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			flags_ff <= 2'b00;
		end else begin
			flags_ff[FLAG_CMD_DONE] <= (flags_ff[FLAG_CMD_DONE] & ~(bus_wr & (reg_addr == ADDR_FLAGS)
			                           & reg_wdata[FLAG_CMD_DONE])) | (cmd_finish & ~host_cmd_wr & ~boot_trig);
			flags_ff[FLAG_TX_DONE]  <= (flags_ff[FLAG_TX_DONE] & ~(bus_wr & (reg_addr == ADDR_FLAGS)
			                           & reg_wdata[FLAG_TX_DONE])) | tx_finish;
		end
	end

	// Read data for the cycle after a read strobe; boot hides other pages.
	always_ff @(posedge core_clk) begin
		if (rst || !reg_rd || (boot_on && !page0)) begin
			rdata_ff <= 8'h00;
		end else begin
			case (reg_addr)
				ADDR_STATUS:     rdata_ff <= {1'b0, accept_ff, boot_on, full, empty, phase_ff};
				ADDR_COMMAND:    rdata_ff <= boot_on ? CMD_BOOT : (state_ff == ST_FETCH) ? CMD_EE_FETCH :
				                             (state_ff == ST_CFG) ? CMD_CFG_LOAD : (state_ff == ST_CALC) ? CMD_CHKSUM :
				                             (state_ff == ST_TX) ? CMD_TRANSMIT : CMD_IDLE;
				ADDR_FIFO_DATA:  rdata_ff <= empty ? 8'h00 : fifo_head;
				ADDR_FIFO_LEVEL: rdata_ff <= {1'b0, level_ff};
				ADDR_FLAGS:      rdata_ff <= {6'h00, flags_ff};
				ADDR_CHK_LOW:    rdata_ff <= chk_bus.result[7:0];
				ADDR_CHK_HIGH:   rdata_ff <= chk_bus.result[15:8];
				ADDR_REDUND:     rdata_ff <= redund_ff;
				ADDR_BIT_PERIOD: rdata_ff <= bit_period_ff;
				default:         rdata_ff <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = rdata_ff;

	// Check-sum feed from the calculate command or the transmitter.
	assign chk_bus.clear = host_cmd_wr & ((reg_wdata == CMD_CHKSUM) | (reg_wdata == CMD_TRANSMIT));
	assign chk_bus.valid = calc_pop | tx_pop;
	assign chk_bus.data  = fifo_head;
	assign chk_bus.crc8  = redund_ff[RED_CRC8_BIT];

	// ****************************************
	// Transmitter
	// ****************************************
	assign tx_abort = cmd_known | boot_trig | (state_ff != ST_TX);
	assign tick_evt = (phase_ff != MODEM_IDLE) & (phase_ff != MODEM_ARMED) & (tick_ff == 8'h00);

	// Picks the next word once the current one has gone out.
	always_comb begin
		nxt_phase = phase_ff;
		nxt_word  = 8'h00;
		nxt_len   = 4'h0;
		tx_pop    = 1'b0;
		tx_finish = 1'b0;
		if (tick_evt && bits_ff == 4'h0) begin
			case (phase_ff)
				MODEM_SOF, MODEM_DATA: begin
					if ((phase_ff == MODEM_SOF || accept_ff) && fifo_avail) begin
						nxt_phase = MODEM_DATA;
						nxt_word  = fifo_head;
						nxt_len   = BYTE_LEN;
						tx_pop    = 1'b1;
					end else if (redund_ff[RED_TX_CHK_BIT]) begin
						nxt_phase = MODEM_CHK;
						nxt_word  = chk_bus.result[7:0];
						nxt_len   = BYTE_LEN;
					end else if (redund_ff[RED_LEGACY_BIT]) begin
						tx_finish = 1'b1;
					end else begin
						nxt_phase = MODEM_EOF;
						nxt_word  = EOF_PATTERN;
						nxt_len   = EOF_LEN;
					end
				end
				MODEM_CHK: begin
					if (!redund_ff[RED_CRC8_BIT] && !chk_hi_ff) begin
						nxt_word = chk_bus.result[15:8];
						nxt_len  = BYTE_LEN;
					end else if (redund_ff[RED_LEGACY_BIT]) begin
						tx_finish = 1'b1;
					end else begin
						nxt_phase = MODEM_EOF;
						nxt_word  = EOF_PATTERN;
						nxt_len   = EOF_LEN;
					end
				end
				MODEM_EOF: tx_finish = 1'b1;
				default:   tx_finish = 1'b0;
			endcase
		end
	end

	// Serialises frames least significant bit first, one bit per period.
	always_ff @(posedge core_clk) begin
		if (rst || tx_abort) begin
			phase_ff  <= (tx_start && !rst) ? MODEM_ARMED : MODEM_IDLE;
			shift_ff  <= 8'h00;
			bits_ff   <= 4'h0;
			tick_ff   <= 8'h00;
			accept_ff <= 1'b0;
			chk_hi_ff <= 1'b0;
			tx_out_ff <= 1'b0;
			tx_en_ff  <= 1'b0;
		end else if (phase_ff == MODEM_ARMED) begin
			if (!empty) begin
				phase_ff <= MODEM_SOF;
				shift_ff <= redund_ff[RED_LEGACY_BIT] ? START_PATTERN : SOF_PATTERN;
				bits_ff  <= redund_ff[RED_LEGACY_BIT] ? START_LEN : SOF_LEN;
				tick_ff  <= 8'h00;
				tx_en_ff <= 1'b1;
			end
		end else if (tick_evt) begin
			tick_ff <= bit_period_ff;
			if (bits_ff != 4'h0) begin
				tx_out_ff <= shift_ff[0];
				shift_ff  <= shift_ff >> 1;
				bits_ff   <= bits_ff - 4'h1;
				if (phase_ff == MODEM_DATA && bits_ff == 4'h1) begin
					accept_ff <= ~empty;
				end
			end else if (tx_finish) begin
				phase_ff  <= MODEM_IDLE;
				tx_out_ff <= 1'b0;
				tx_en_ff  <= 1'b0;
			end else begin
				phase_ff  <= nxt_phase;
				tx_out_ff <= nxt_word[0];
				shift_ff  <= nxt_word >> 1;
				bits_ff   <= nxt_len - 4'h1;
				if (phase_ff == MODEM_CHK) begin
					chk_hi_ff <= 1'b1;
				end
			end
		end else if (tick_ff != 8'h00) begin
			tick_ff <= tick_ff - 8'h01;
		end
	end

	assign tx_out = tx_out_ff;
	assign tx_en  = tx_en_ff;

endmodule // reader_command_sequencer_tx

// [tb/seq_monitor.sv]
// Port checker for the command sequencer.
`timescale 1ns/10ps
module seq_monitor
	import seq_pkg::*;
(
	// Clock and reset
	input wire logic             core_clk,
	input wire logic             rst,
	// Register port
	input wire logic [5:0]       reg_addr,
	input wire logic [7:0]       reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [7:0]       reg_rdata,
	// Boot events
	input wire logic             digital_supply_pin,
	input wire logic             analog_supply_pin,
	input wire logic             reset_powerdown_pin,
	// EEPROM and RF
	input wire logic [EE_AW-1:0] ee_addr,
	input wire logic             ee_rd,
	input wire logic [7:0]       ee_rdata,
	input wire logic             tx_out,
	input wire logic             tx_en
);
	// ****
	// Checks
	// ****
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Boot fetches its image right after reset or a reset pin fall.
	boot_fetch_a: assert property ($fell(rst) |-> ##[0:2] (ee_rd && ee_addr == BOOT_EE_ADDR))
		else $error("boot fetch missing after reset");
	pin_boot_a: assert property ($fell(reset_powerdown_pin) |-> ##[0:3] (ee_rd && ee_addr == BOOT_EE_ADDR))
		else $error("boot fetch missing after pin fall");
	// Requests come every third cycle: request, data, an idle cycle, then the next request.
	boot_pair_a: assert property (ee_rd && ee_addr == BOOT_EE_ADDR |-> ##3 ee_rd)
		else $error("second boot byte not fetched");
	// EEPROM requests are single pulses at rising addresses.
	ee_pulse_a: assert property (ee_rd |=> !ee_rd)
		else $error("eeprom request longer than one cycle");
	ee_ascend_a: assert property (ee_rd ##3 ee_rd |-> ee_addr == $past(ee_addr, 3) + 9'h001)
		else $error("eeprom address not ascending");
	// A forced idle drops the carrier at once.
	tx_drop_a: assert property (tx_en && reg_wr && reg_addr == ADDR_COMMAND && reg_wdata == CMD_IDLE
		|=> !tx_en [*3])
		else $error("output not halted by idle write");
	// Every bit stands eight cycles with the boot bit period.
	bit_hold_a: assert property (tx_en && $changed(tx_out) |=> (!tx_en || $stable(tx_out)) [*7])
		else $error("bit shorter than its period");
	// The start pattern begins with a zero then a one.
	sof_start_a: assert property ($rose(tx_en) |=> tx_out == 1'b0 ##8 tx_out == 1'b1)
		else $error("start pattern wrong");
endmodule // seq_monitor
bind reader_command_sequencer_tx seq_monitor MON (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .digital_supply_pin, .analog_supply_pin, .reset_powerdown_pin, .ee_addr, .ee_rd, .ee_rdata,
	.tx_out, .tx_en);

// [tb/ee_model.sv]
// EEPROM of one cycle read latency beside the sequencer.
`timescale 1ns/10ps
module ee_model
	import seq_pkg::*;
(
	// Clock
	input wire logic             core_clk,
	// Read port
	input wire logic [EE_AW-1:0] ee_addr,
	input wire logic             ee_rd,
	output logic     [7:0]       ee_rdata = 8'h00
);
	// ****
	// Storage
	// ****
	// Boot image holds standard framing and period 07; elsewhere a pattern.
	function automatic logic [7:0] img(input logic [EE_AW-1:0] a);
		if (a == BOOT_EE_ADDR + 9'h001) return 8'h07;
		return (a == BOOT_EE_ADDR) ? 8'h00 : a[7:0] ^ 8'h5A;
	endfunction
	// Data stand only in the cycle after a request; the bus toggles otherwise.
	always_ff @(posedge core_clk) begin
		ee_rdata <= ee_rd ? img(ee_addr) : ~ee_rdata;
	end
endmodule // ee_model

// [tb/tb.sv]
// Self-checking bench for the command sequencer.
`timescale 1ns/10ps
module tb;
	import seq_pkg::*;
	logic             core_clk = 1'b0;
	logic             rst = 1'b1;
	logic [5:0]       reg_addr = 6'h00;
	logic [7:0]       reg_wdata = 8'h00;
	logic             reg_wr = 1'b0;
	logic             reg_rd = 1'b0;
	logic             digital_supply_pin = 1'b1;
	logic             analog_supply_pin = 1'b1;
	logic             reset_powerdown_pin = 1'b1;
	logic [7:0]       reg_rdata, ee_rdata, v8;
	logic [EE_AW-1:0] ee_addr;
	logic             ee_rd, tx_out, tx_en;
	logic [63:0]      fr;
	logic [15:0]      c;
	int               bad_count = 0;
	int               cmp_count = 0;
	// ****
	// Instances
	// ****
	reader_command_sequencer_tx DUT (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.digital_supply_pin, .analog_supply_pin, .reset_powerdown_pin, .ee_addr, .ee_rd, .ee_rdata,
		.tx_out, .tx_en);
	ee_model EE (.core_clk, .ee_addr, .ee_rd, .ee_rdata);
	// ****
	// Tasks
	// ****
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk($sformatf("register %h", a), 64'(e), 64'(d));
	endtask
	// Polls the command register until the sequencer reports idle.
	task automatic wait_idle;
		logic [7:0] d;
		d = 8'hFF;
		for (int i = 0; i < 400 && d !== CMD_IDLE; i++) rd(ADDR_COMMAND, d);
		chk("command", 64'(CMD_IDLE), 64'(d));
	endtask
	// Fetches from the given address and checks the bytes that may return.
	task automatic fetch(input logic [7:0] lo, input logic [7:0] cnt, input logic [7:0] keep);
		wr(ADDR_FLAGS, 8'h03);
		wr(ADDR_FIFO_DATA, lo);
		wr(ADDR_FIFO_DATA, 8'h00);
		wr(ADDR_FIFO_DATA, cnt);
		wr(ADDR_COMMAND, CMD_EE_FETCH);
		wait_idle;
		rchk(ADDR_FIFO_LEVEL, keep);
		for (int i = 0; i < keep; i++) rchk(ADDR_FIFO_DATA, (lo + 8'(i)) ^ 8'h5A);
		rchk(ADDR_FLAGS, 8'h01);
	endtask
	// Samples n frame bits near the middle of each bit, first bit at index 0.
	task automatic cap(input int n, output logic [63:0] v);
		v = '0;
		for (int i = 0; i < 3000 && tx_en !== 1'b1; i++) @(negedge core_clk);
		repeat (5) @(negedge core_clk);
		for (int k = 0; k < n; k++) begin
			v[k] = tx_out;
			repeat (8) @(negedge core_clk);
		end
	endtask
	function automatic logic [15:0] crc(input logic [15:0] s, input logic [7:0] b);
		logic [15:0] r;
		r = s ^ {8'h00, b};
		for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ CRC16_POLY : r >> 1;
		return r;
	endfunction
	// ****
	// Sequence
	// ****
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	// Cuts a hang short.
	initial begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		wait_idle;
		rchk(ADDR_FLAGS, 8'h01);
		rchk(ADDR_REDUND, 8'h00);
		rchk(ADDR_BIT_PERIOD, 8'h07);
		rchk(6'h07, 8'h00);
		fetch(8'h20, 8'h03, 8'h03);
		fetch(8'h7F, 8'h02, 8'h01);
		// Config load from 0x030 then restore framing and period.
		wr(ADDR_FIFO_DATA, 8'h30);
		wr(ADDR_FIFO_DATA, 8'h00);
		wr(ADDR_COMMAND, CMD_CFG_LOAD);
		wait_idle;
		rchk(ADDR_REDUND, 8'h6A);
		rchk(ADDR_BIT_PERIOD, 8'h6B);
		wr(ADDR_REDUND, 8'h00);
		wr(ADDR_BIT_PERIOD, 8'h07);
		// Check-sum over two bytes.
		wr(ADDR_FIFO_DATA, 8'h11);
		wr(ADDR_FIFO_DATA, 8'h22);
		wr(ADDR_COMMAND, CMD_CHKSUM);
		wait_idle;
		c = crc(crc(CRC16_PRESET, 8'h11), 8'h22);
		rchk(ADDR_CHK_LOW, c[7:0]);
		rchk(ADDR_CHK_HIGH, c[15:8]);
		// Preloaded single-byte frame.
		wr(ADDR_FLAGS, 8'h03);
		wr(ADDR_FIFO_DATA, 8'hA5);
		wr(ADDR_COMMAND, CMD_TRANSMIT);
		cap(24, fr);
		chk("frame", {40'h0, EOF_PATTERN, 8'hA5, SOF_PATTERN}, fr);
		wait_idle;
		rchk(ADDR_FLAGS, 8'h03);
		// Armed on an empty FIFO, second byte appended; a byte after accept-more fell stays behind.
		wr(ADDR_COMMAND, CMD_TRANSMIT);
		repeat (20) @(negedge core_clk);
		chk("tx_en", 64'h0, 64'(tx_en));
		rd(ADDR_STATUS, v8);
		chk("modem", 64'(MODEM_ARMED), 64'(v8[2:0]));
		fork
			cap(32, fr);
			begin
				wr(ADDR_FIFO_DATA, 8'h5C);
				wr(ADDR_FIFO_DATA, 8'h6D);
				repeat (200) @(posedge core_clk);
				wr(ADDR_FIFO_DATA, 8'h7E);
			end
		join
		chk("frame", {32'h0, EOF_PATTERN, 8'h6D, 8'h5C, SOF_PATTERN}, fr);
		wait_idle;
		rchk(ADDR_FIFO_LEVEL, 8'h01);
		rchk(ADDR_FIFO_DATA, 8'h7E);
		// Frame with the check-sum appended, low byte first.
		wr(ADDR_REDUND, 8'h01);
		wr(ADDR_FIFO_DATA, 8'h99);
		wr(ADDR_COMMAND, CMD_TRANSMIT);
		cap(40, fr);
		c = crc(CRC16_PRESET, 8'h99);
		chk("frame", {24'h0, EOF_PATTERN, c, 8'h99, SOF_PATTERN}, fr);
		wait_idle;
		wr(ADDR_REDUND, 8'h00);
		// Forced idle in mid-frame keeps the FIFO and raises no flag.
		wr(ADDR_FLAGS, 8'h03);
		wr(ADDR_FIFO_DATA, 8'h12);
		wr(ADDR_FIFO_DATA, 8'h34);
		wr(ADDR_COMMAND, CMD_TRANSMIT);
		repeat (30) @(posedge core_clk);
		wr(ADDR_COMMAND, CMD_IDLE);
		@(negedge core_clk);
		chk("tx_en", 64'h0, 64'(tx_en));
		rchk(ADDR_FLAGS, 8'h00);
		rchk(ADDR_FIFO_LEVEL, 8'h02);
		rchk(ADDR_FIFO_DATA, 8'h12);
		rchk(ADDR_FIFO_DATA, 8'h34);
		// Pin-started boot ignores a write and serves page 0 only.
		@(posedge core_clk);
		reset_powerdown_pin <= 1'b0;
		wr(ADDR_COMMAND, CMD_TRANSMIT);
		rchk(ADDR_BIT_PERIOD, 8'h00);
		@(posedge core_clk);
		reset_powerdown_pin <= 1'b1;
		wait_idle;
		rchk(ADDR_FLAGS, 8'h01);
		// Each supply power-up restarts boot on its own.
		@(posedge core_clk);
		digital_supply_pin <= 1'b0;
		analog_supply_pin <= 1'b0;
		@(posedge core_clk);
		digital_supply_pin <= 1'b1;
		rchk(ADDR_COMMAND, CMD_BOOT);
		wait_idle;
		@(posedge core_clk);
		analog_supply_pin <= 1'b1;
		rchk(ADDR_COMMAND, CMD_BOOT);
		wait_idle;
		final_report;
	end
endmodule // tb
